// ### rtl/ddr2_cmd_defines.svh
`ifndef DDR2_CMD_DEFINES_SVH
`define DDR2_CMD_DEFINES_SVH
// How it works
// - Additive latency field E3-E5, values 0..6.
// - Early column command only when AL within tRCD.
// - Device delays column commands by AL clocks.
// - Read latency equals AL plus CL.
// - Write latency is read latency minus one.
// - Controller keeps driver calibration at default.
// - EMR2 bit E7 selects fast refresh.
// - Extended loads only when idle, then tMRD.
// - Mode registers hold value until reloaded.
// - Bits E16 and above E12 written zero.
// - NOP for 200 us, then raise CKE.
// - Wait 400 ns, then precharge all.
// - CKE stays high through initialization.
// - Bank address selects the mode register.
// - Load EMR2, EMR3, EMR DLL on, MR DLL reset.
// - Precharge all, two refreshes, MR operating load.
// - EMR calibration default, then calibration exit.
// - Ready 200 clocks after DLL reset.
// - Activate a row before read or write.
// - Times convert to clocks rounding up.
// - Same bank tRC, different bank tRRD; the code waits the longer of tRRD and tRCD after an activate to any bank.
// - At most four activates per tFAW.
// - CAS latency field M4-M6, 3..7 clocks.
// - No read within 200 clocks of DLL reset.

`define CLK_PERIOD_PS      125000/1000*8
`define T_PWRUP_NS         200000
`define T_CKE_PRE_NS       400
`define T_RCD_NS           15
`define T_RRD_NS           10
`define T_RC_NS            55
`define T_FAW_NS           45
`define T_MRD_CK           2
`define T_RFC_NS           195
`define T_RP_NS            15
`define DLL_LOCK_CK        200
`define AL_LSB             3
`define AL_MAX             6
`define CL_LSB             4
`define CL_MIN             3
`define CL_MAX             7
`define DLL_OFF_BIT        0
`define DLL_RESET_BIT      8
`define OCD_LSB            7
`define FAST_REFRESH_BIT   7
`define APB_CTRL           8'h00
`define APB_MODE           8'h04
`define APB_EXT            8'h08
`define APB_STAT           8'h0c
`define APB_CMD            8'h10
`define CTRL_START_BIT     0
`define CTRL_HOT_BIT       1
`endif

// ### rtl/ddr2_cmd_pkg.sv
package ddr2_cmd_pkg;
    typedef enum logic [2:0]
    {
        CMD_NOP  = 3'h0,
        CMD_LM   = 3'h1,
        CMD_REF  = 3'h2,
        CMD_PRE  = 3'h3,
        CMD_ACT  = 3'h4,
        CMD_RD   = 3'h5,
        CMD_WR   = 3'h6
    } cmd_t;
endpackage

// ### rtl/ddr2_link_if.sv
`timescale 1ns/1ns
interface ddr2_link_if;
    logic                cke;
    ddr2_cmd_pkg::cmd_t  cmd;
    logic [2:0]          bank;
    logic [13:0]         addr;
    logic                rdValid;
    logic                wrWindow;
    logic                ready;
    modport ctrl
    (
        output cke,
        output cmd,
        output bank,
        output addr,
        input  rdValid,
        input  wrWindow,
        input  ready
    );
    modport mem
    (
        input  cke,
        input  cmd,
        input  bank,
        input  addr,
        output rdValid,
        output wrWindow,
        output ready
    );
endinterface

// ### rtl/ddr2_delay_line.sv
`timescale 1ns/1ns
module ddr2_delay_line
#(
    parameter int DEPTH = 16
)
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        clkEn,
    input  wire logic        din,
    input  wire logic [3:0]  tap,
    output logic             dout
);
    logic [DEPTH-1:0] line;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            line <= '0;
        else if (clkEn)
            line <= {line[DEPTH-2:0], din};
    end

    // Tap zero means the event leaves on the edge after it arrived.
    always_comb
    begin
        dout = line[tap];
    end
endmodule

// ### rtl/ddr2_mem_end.sv
`timescale 1ns/1ns
`include "ddr2_cmd_defines.svh"
module ddr2_mem_end
(
    input  wire logic  clk,
    input  wire logic  sys_rst,
    input  wire logic  clkEn,
    ddr2_link_if.mem   link,
    output logic [2:0] addLat,
    output logic [2:0] casLat,
    output logic       hotRefresh
);
    // ========================================
    // Mode registers
    logic [13:0] modeReg;
    logic [13:0] extReg;
    logic [13:0] ext2Reg;
    logic [13:0] ext3Reg;
    logic [7:0]  lockCnt;
    logic        cmdLoad;

    always_comb
    begin
        cmdLoad = link.cke && link.cmd == ddr2_cmd_pkg::CMD_LM;
    end

    // Values stay until the next load.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            modeReg <= 14'h0000;
            extReg  <= 14'h0000;
            ext2Reg <= 14'h0000;
            ext3Reg <= 14'h0000;
        end
        else if (clkEn && cmdLoad)
        begin
            unique case (link.bank[1:0])
                2'h0: modeReg <= link.addr;
                2'h1: extReg  <= link.addr;
                2'h2: ext2Reg <= link.addr;
                2'h3: ext3Reg <= link.addr;
            endcase
        end
    end

    // DLL lock counter restarts on reset load.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            lockCnt <= 8'h00;
        else if (clkEn)
        begin
            if (cmdLoad && link.bank[1:0] == 2'h0 && link.addr[`DLL_RESET_BIT])
                lockCnt <= 8'(`DLL_LOCK_CK);
            else if (lockCnt != 8'h00)
                lockCnt <= lockCnt - 8'h01;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            link.ready <= 1'b0;
        else if (clkEn)
            link.ready <= lockCnt == 8'h01 || (link.ready && !(cmdLoad && link.addr[`DLL_RESET_BIT]
                          && link.bank[1:0] == 2'h0));
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            addLat     <= 3'h0;
            casLat     <= 3'h0;
            hotRefresh <= 1'b0;
        end
        else if (clkEn)
        begin
            addLat     <= extReg[`AL_LSB +: 3];
            casLat     <= modeReg[`CL_LSB +: 3];
            hotRefresh <= ext2Reg[`FAST_REFRESH_BIT];
        end
    end

    // ========================================
    // Posted column commands
    logic       isRd;
    logic       isWr;
    logic       rdInt;
    logic       wrInt;
    logic [3:0] rdTap;
    logic [3:0] wrTap;

    always_comb
    begin
        isRd  = link.cke && link.cmd == ddr2_cmd_pkg::CMD_RD;
        isWr  = link.cke && link.cmd == ddr2_cmd_pkg::CMD_WR;
        // Read latency is AL plus CL; line and output flop take two edges.
        rdTap = 4'(addLat) + 4'(casLat) - 4'h2;
        wrTap = 4'(addLat) + 4'(casLat) - 4'h3;
    end

    // Column commands are held AL plus CL clocks before use, one clock less for writes.
    ddr2_delay_line #(.DEPTH(16)) rdLine
    (
        .clk     (clk),
        .sys_rst (sys_rst),
        .clkEn   (clkEn),
        .din     (isRd),
        .tap     (rdTap),
        .dout    (rdInt)
    );

    ddr2_delay_line #(.DEPTH(16)) wrLine
    (
        .clk     (clk),
        .sys_rst (sys_rst),
        .clkEn   (clkEn),
        .din     (isWr),
        .tap     (wrTap),
        .dout    (wrInt)
    );

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            link.rdValid  <= 1'b0;
            link.wrWindow <= 1'b0;
        end
        else if (clkEn)
        begin
            link.rdValid  <= rdInt;
            link.wrWindow <= wrInt;
        end
    end
endmodule

// ### rtl/ddr2_ctrl_end.sv
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`include "ddr2_cmd_defines.svh"
module ddr2_ctrl_end
#(
    parameter int PWRUP_CK = (`T_PWRUP_NS + 7) / 8
)
(
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         clkEn,
    ddr2_link_if.ctrl         link,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr
);
    // Minimum times round up to whole 8 ns clocks.
    localparam int CK_PRE = (`T_CKE_PRE_NS + 7) / 8;
    localparam int CK_RCD = (`T_RCD_NS + 7) / 8;
    localparam int CK_RRD = (`T_RRD_NS + 7) / 8;
    localparam int CK_RC  = (`T_RC_NS + 7) / 8;
    localparam int CK_FAW = (`T_FAW_NS + 7) / 8;
    localparam int CK_RFC = (`T_RFC_NS + 7) / 8;
    localparam int CK_RP  = (`T_RP_NS + 7) / 8;

    typedef enum logic [3:0]
    {
        S_RESET  = 4'h0,
        S_WAIT   = 4'h1,
        S_CKE    = 4'h2,
        S_PRE1   = 4'h3,
        S_EMR2   = 4'h4,
        S_EMR3   = 4'h5,
        S_EMRDLL = 4'h6,
        S_MRRST  = 4'h7,
        S_PRE2   = 4'h8,
        S_REF1   = 4'h9,
        S_REF2   = 4'ha,
        S_MROP   = 4'hb,
        S_OCDDEF = 4'hc,
        S_OCDX   = 4'hd,
        S_LOCK   = 4'he,
        S_RUN    = 4'hf
    } init_t;

    // ========================================
    // Register bus
    logic [31:0] ctrlReg;
    logic [13:0] modeVal;
    logic [13:0] extVal;
    logic [31:0] cmdReg;
    logic        cmdPend;
    logic        cmdDone;
    logic        busWr;
    logic        mapped;
    init_t       state;

    always_comb
    begin
        busWr  = psel && penable && pwrite;
        mapped = paddr == `APB_CTRL || paddr == `APB_MODE || paddr == `APB_EXT
                 || paddr == `APB_STAT || paddr == `APB_CMD;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
        else if (clkEn)
        begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            unique case (paddr)
                `APB_CTRL: prdata <= ctrlReg;
                `APB_MODE: prdata <= {18'h00000, modeVal};
                `APB_EXT:  prdata <= {18'h00000, extVal};
                `APB_STAT: prdata <= {26'h0000000, cmdPend, link.ready, state};
                `APB_CMD:  prdata <= cmdReg;
                default:   prdata <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ctrlReg <= 32'h00000000;
            modeVal <= 14'h0000;
            extVal  <= 14'h0000;
            cmdReg  <= 32'h00000000;
        end
        else if (clkEn && busWr && pready)
        begin
            if (paddr == `APB_CTRL)
                ctrlReg <= pwdata;
            // Only CAS latencies 3..7 are accepted.
            if (paddr == `APB_MODE && pwdata[`CL_LSB +: 3] >= 3'(`CL_MIN))
                modeVal <= pwdata[13:0] & 14'h1eff;
            // Reserved additive latency codes are refused.
            // Calibration bits are forced to zero, the calibration exit code.
            if (paddr == `APB_EXT && pwdata[`AL_LSB +: 3] <= 3'(`AL_MAX))
                extVal <= pwdata[13:0] & 14'h1c7e;
            if (paddr == `APB_CMD)
                cmdReg <= pwdata;
        end
    end

    // Set wins over clear: a new order in the finishing cycle is kept.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            cmdPend <= 1'b0;
        else if (clkEn)
        begin
            if (busWr && pready && paddr == `APB_CMD)
                cmdPend <= 1'b1;
            else if (cmdDone)
                cmdPend <= 1'b0;
        end
    end

    // ========================================
    // Initialization sequence
    logic [15:0] waitCnt;
    logic [15:0] gapCnt;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state   <= S_RESET;
            waitCnt <= 16'h0000;
        end
        else if (clkEn)
        begin
            if (waitCnt != 16'h0000)
                waitCnt <= waitCnt - 16'h0001;
            else
            begin
                unique case (state)
                    S_RESET:  if (ctrlReg[`CTRL_START_BIT])
                              begin
                                  state   <= S_WAIT;
                                  waitCnt <= 16'(PWRUP_CK);
                              end
                    S_WAIT:   begin
                                  state   <= S_CKE;
                                  waitCnt <= 16'(CK_PRE);
                              end
                    S_CKE:    begin state <= S_PRE1;   waitCnt <= 16'(CK_RP); end
                    S_PRE1:   begin state <= S_EMR2;   waitCnt <= 16'(`T_MRD_CK); end
                    S_EMR2:   begin state <= S_EMR3;   waitCnt <= 16'(`T_MRD_CK); end
                    S_EMR3:   begin state <= S_EMRDLL; waitCnt <= 16'(`T_MRD_CK); end
                    S_EMRDLL: begin state <= S_MRRST;  waitCnt <= 16'(`T_MRD_CK); end
                    S_MRRST:  begin state <= S_PRE2;   waitCnt <= 16'(CK_RP); end
                    S_PRE2:   begin state <= S_REF1;   waitCnt <= 16'(CK_RFC); end
                    S_REF1:   begin state <= S_REF2;   waitCnt <= 16'(CK_RFC); end
                    S_REF2:   begin state <= S_MROP;   waitCnt <= 16'(`T_MRD_CK); end
                    S_MROP:   begin state <= S_OCDDEF; waitCnt <= 16'(`T_MRD_CK); end
                    S_OCDDEF: begin state <= S_OCDX;   waitCnt <= 16'(`T_MRD_CK); end
                    // Reads wait for the DLL to lock.
                    S_OCDX:   state <= S_LOCK;
                    S_LOCK:   if (link.ready) state <= S_RUN;
                    S_RUN:    state <= S_RUN;
                endcase
            end
        end
    end

    // Every load is issued with all banks idle and followed by tMRD.
    // Bits above E12 go out as zero on a 14-bit bus masked to 13 bits.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            link.cke  <= 1'b0;
            link.cmd  <= ddr2_cmd_pkg::CMD_NOP;
            link.bank <= 3'h0;
            link.addr <= 14'h0000;
        end
        else if (clkEn)
        begin
            link.cmd  <= ddr2_cmd_pkg::CMD_NOP;
            link.bank <= 3'h0;
            link.addr <= 14'h0000;
            if (state == S_CKE || link.cke)
                link.cke <= 1'b1;
            if (waitCnt == 16'h0000)
            begin
                unique case (state)
                    S_PRE1, S_PRE2: begin link.cmd <= ddr2_cmd_pkg::CMD_PRE; link.addr <= 14'h0400; end
                    // Loads in order, bank bits per target.
                    S_EMR2:   begin link.cmd <= ddr2_cmd_pkg::CMD_LM; link.bank <= 3'h2;
                                    link.addr <= {6'h00, ctrlReg[`CTRL_HOT_BIT], 7'h00}; end
                    S_EMR3:   begin link.cmd <= ddr2_cmd_pkg::CMD_LM; link.bank <= 3'h3; end
                    S_EMRDLL: begin link.cmd <= ddr2_cmd_pkg::CMD_LM; link.bank <= 3'h1; end
                    S_MRRST:  begin link.cmd <= ddr2_cmd_pkg::CMD_LM; link.addr <= 14'h0100; end
                    // Two refreshes, then operating load with A8 low.
                    S_REF1, S_REF2: link.cmd <= ddr2_cmd_pkg::CMD_REF;
                    S_MROP:   begin link.cmd <= ddr2_cmd_pkg::CMD_LM; link.addr <= modeVal; end
                    S_OCDDEF: begin link.cmd <= ddr2_cmd_pkg::CMD_LM; link.bank <= 3'h1;
                                    link.addr <= extVal | 14'h0380; end
                    S_OCDX:   begin link.cmd <= ddr2_cmd_pkg::CMD_LM; link.bank <= 3'h1;
                                    link.addr <= extVal; end
                    S_RUN:    if (cmdPend && !cmdDone && gapCnt == 16'h0000)
                              begin
                                  link.cmd  <= ddr2_cmd_pkg::cmd_t'(cmdReg[18:16]);
                                  link.bank <= cmdReg[22:20];
                                  link.addr <= cmdReg[13:0];
                              end
                    default:  link.cmd <= ddr2_cmd_pkg::CMD_NOP;
                endcase
            end
        end
    end

    // ========================================
    // Activate spacing for software orders
    logic [7:0]  openBank;
    logic [15:0] fawCnt [4];
    logic        isAct;
    logic [2:0]  activeFaw;

    always_comb
    begin
        isAct     = cmdReg[18:16] == 3'(ddr2_cmd_pkg::CMD_ACT);
        activeFaw = 3'h0;
        for (int i = 0; i < 4; i++)
            activeFaw = activeFaw + 3'(fawCnt[i] != 16'h0000);
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            cmdDone <= 1'b0;
        else if (clkEn)
            cmdDone <= state == S_RUN && cmdPend && !cmdDone && gapCnt == 16'h0000 && waitCnt == 16'h0000;
    end

    // Spacing after each order: an activate waits the longer of tRRD and tRCD, any other order one clock.
    // Column orders also wait out tRCD after an activate.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            gapCnt <= 16'h0000;
        else if (clkEn)
        begin
            if (cmdDone)
                gapCnt <= isAct ? 16'(CK_RRD > CK_RCD ? CK_RRD : CK_RCD) : 16'h0001;
            // Fifth activate waits while four windows run.
            else if (cmdPend && isAct && activeFaw == 3'h4)
                gapCnt <= 16'h0001;
            // A column order to a closed bank is held back.
            else if (cmdPend && (cmdReg[18:16] == 3'(ddr2_cmd_pkg::CMD_RD)
                     || cmdReg[18:16] == 3'(ddr2_cmd_pkg::CMD_WR)) && !openBank[cmdReg[22:20]])
                gapCnt <= 16'h0001;
            else if (gapCnt != 16'h0000)
                gapCnt <= gapCnt - 16'h0001;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            openBank <= 8'h00;
        else if (clkEn && cmdDone)
        begin
            if (isAct)
                openBank[cmdReg[22:20]] <= 1'b1;
            else if (cmdReg[18:16] == 3'(ddr2_cmd_pkg::CMD_PRE))
                openBank <= cmdReg[10] ? 8'h00 : openBank & ~(8'h01 << cmdReg[22:20]);
        end
    end

    generate
        for (genvar g = 0; g < 4; g++)
        begin : faw
            always_ff @(posedge clk)
            begin
                if (sys_rst)
                    fawCnt[g] <= 16'h0000;
                else if (clkEn)
                begin
                    if (cmdDone && isAct && fawCnt[g] == 16'h0000 && activeFaw == 3'(g))
                        fawCnt[g] <= 16'(CK_FAW > CK_RC ? CK_FAW : CK_RC);
                    else if (fawCnt[g] != 16'h0000)
                        fawCnt[g] <= fawCnt[g] - 16'h0001;
                end
            end
        end
    endgenerate
endmodule

// ### tb/ddr2_link_props.sv
`timescale 1ns/1ns
// ==========
// Checker for the command link between both ends.
module ddr2_link_props
(
    input wire logic               clk,
    input wire logic               sys_rst,
    input wire logic               cke,
    input wire ddr2_cmd_pkg::cmd_t cmd,
    input wire logic [2:0]         bank,
    input wire logic [13:0]        addr,
    input wire logic               rdValid,
    input wire logic               wrWindow,
    input wire logic               ready
);
    logic        lm;
    logic [2:0]  al;
    logic [2:0]  cl;
    logic [3:0]  rl;
    logic [15:0] rdHist;
    logic [15:0] wrHist;
    logic [7:0]  ckeCnt;
    logic [8:0]  dllCnt;
    logic        dllSeen;
    assign lm = cke && cmd == ddr2_cmd_pkg::CMD_LM;
    assign rl = 4'(al) + 4'(cl);
    // ==========
    // Reference latencies come from the loads seen on the wire.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            al <= 3'h0;
            cl <= 3'h0;
        end
        else if (lm && bank == 3'h1)
            al <= addr[5:3];
        else if (lm && bank == 3'h0)
            cl <= addr[6:4];
    end
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rdHist <= 16'h0;
            wrHist <= 16'h0;
        end
        else
        begin
            rdHist <= {rdHist[14:0], cke && cmd == ddr2_cmd_pkg::CMD_RD};
            wrHist <= {wrHist[14:0], cke && cmd == ddr2_cmd_pkg::CMD_WR};
        end
    end
    // Counters saturate, so a long idle run cannot wrap them back into range.
    always_ff @(posedge clk)
    begin
        if (sys_rst || !cke)
            ckeCnt <= 8'h0;
        else if (ckeCnt != 8'hff)
            ckeCnt <= ckeCnt + 8'h1;
    end
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            dllSeen <= 1'h0;
        else if (lm && bank == 3'h0 && addr[8])
            dllSeen <= 1'h1;
    end
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            dllCnt <= 9'h0;
        else if (lm && bank == 3'h0 && addr[8])
            dllCnt <= 9'h1;
        else if (dllCnt != 9'h1ff)
            dllCnt <= dllCnt + 9'h1;
    end
    // ==========
    // Assertions.
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_nop_until_cke:
        assert property (!cke |-> cmd == ddr2_cmd_pkg::CMD_NOP) else $error("command with cke low");
    a_cke_to_precharge:
        assert property (cke && cmd != ddr2_cmd_pkg::CMD_NOP |-> ckeCnt >= 8'd49) else $error("command too soon");
    a_cke_held:
        assert property (cke |=> cke) else $error("cke dropped");
    a_top_bits_zero:
        assert property (lm |-> !addr[13] && !bank[2]) else $error("reserved mode bit set");
    a_emr2_reserved:
        assert property (lm && bank == 3'h2 |-> (addr & 14'h3f7f) == 14'h0) else $error("emr2 reserved bit");
    a_mrd_gap:
        assert property (lm |=> cmd == ddr2_cmd_pkg::CMD_NOP) else $error("mode load gap short");
    a_al_legal:
        assert property (lm && bank == 3'h1 |-> addr[5:3] != 3'h7) else $error("reserved additive latency");
    a_ready_not_early:
        assert property (ready |-> dllSeen && dllCnt >= 9'd200) else $error("ready too early");
    a_read_after_lock:
        assert property (cke && cmd == ddr2_cmd_pkg::CMD_RD |-> dllSeen && dllCnt >= 9'd200) else $error("read early");
    a_read_latency:
        assert property (rl >= 4'h2 |-> rdValid == rdHist[rl - 4'h1]) else $error("read latency wrong");
    a_write_latency:
        assert property (rl >= 4'h2 |-> wrWindow == wrHist[rl - 4'h2]) else $error("write latency wrong");
    a_act_spacing:
        assert property (cke && cmd == ddr2_cmd_pkg::CMD_ACT |=> cmd != ddr2_cmd_pkg::CMD_ACT) else $error("act gap");
    a_ocd_exit:
        assert property (lm && bank == 3'h1 && addr[9:7] == 3'h7 |-> ##[2:60] (lm && bank == 3'h1 && addr[9:7] == 3'h0))
        else $error("no calibration exit");
    c_read: cover property (rdValid);
    c_write: cover property (wrWindow);
    c_ready: cover property ($rose(ready));
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ns
`include "ddr2_cmd_defines.svh"
`define CHECK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
module testbench;
    localparam ddr2_cmd_pkg::cmd_t LM = ddr2_cmd_pkg::CMD_LM;
    localparam ddr2_cmd_pkg::cmd_t PR = ddr2_cmd_pkg::CMD_PRE;
    localparam ddr2_cmd_pkg::cmd_t RF = ddr2_cmd_pkg::CMD_REF;
    logic        clk = 1'h0;
    logic        sys_rst = 1'h1;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  addLat;
    logic [2:0]  casLat;
    logic        hotRefresh;
    logic [31:0] rdat;
    logic        err;
    logic [19:0] cmdLog[$];
    int          mismatches = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          rdAt;
    int          wrAt;
    int          rdGap;
    int          wrGap;
    ddr2_link_if ddr2_link_if_i ();
    ddr2_ctrl_end #(.PWRUP_CK(10)) ddr2_ctrl_end_i (.clk(clk), .sys_rst(sys_rst), .clkEn(1'h1),
        .link(ddr2_link_if_i.ctrl), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    ddr2_mem_end ddr2_mem_end_i (.clk(clk), .sys_rst(sys_rst), .clkEn(1'h1), .link(ddr2_link_if_i.mem),
        .addLat(addLat), .casLat(casLat), .hotRefresh(hotRefresh));
    ddr2_link_props ddr2_link_props_i (.clk(clk), .sys_rst(sys_rst), .cke(ddr2_link_if_i.cke),
        .cmd(ddr2_link_if_i.cmd), .bank(ddr2_link_if_i.bank), .addr(ddr2_link_if_i.addr),
        .rdValid(ddr2_link_if_i.rdValid), .wrWindow(ddr2_link_if_i.wrWindow), .ready(ddr2_link_if_i.ready));
    always #4 clk = ~clk;
    // ==========
    // Link monitor: logs commands and measures data latencies.
    always @(posedge clk)
    begin
        cyc++;
        if (ddr2_link_if_i.cke === 1'h1 && ddr2_link_if_i.cmd !== ddr2_cmd_pkg::CMD_NOP)
            cmdLog.push_back({ddr2_link_if_i.cmd, ddr2_link_if_i.bank, ddr2_link_if_i.addr});
        if (ddr2_link_if_i.cke === 1'h1 && ddr2_link_if_i.cmd === ddr2_cmd_pkg::CMD_RD)
            rdAt = cyc;
        if (ddr2_link_if_i.cke === 1'h1 && ddr2_link_if_i.cmd === ddr2_cmd_pkg::CMD_WR)
            wrAt = cyc;
        if (ddr2_link_if_i.rdValid === 1'h1)
            rdGap = cyc - rdAt;
        if (ddr2_link_if_i.wrWindow === 1'h1)
            wrGap = cyc - wrAt;
    end
    // ==========
    // Bus access and tests.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'h1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // A new order is only written once the previous one has left, so none is lost.
    task automatic order(input ddr2_cmd_pkg::cmd_t c, input logic [2:0] b, input logic [13:0] a);
        apb(1'h1, `APB_CMD, {9'h0, b, 1'h0, c, 2'h0, a});
        do
            apb(1'h0, `APB_STAT, 32'h0);
        while (rdat[5] !== 1'h0);
    endtask
    task automatic run_cfg(input logic hot, input logic [13:0] ext, input logic [13:0] mode);
        logic [19:0] exp[11];
        logic [19:0] msk[11];
        exp = '{{PR, 17'h00400}, {LM, 3'h2, 6'h0, hot, 7'h0}, {LM, 17'h0c000}, {LM, 3'h1, 14'h0},
                {LM, 17'h00100}, {PR, 17'h00400}, {RF, 17'h0}, {RF, 17'h0}, {LM, 3'h0, mode},
                {LM, 3'h1, ext | 14'h0380}, {LM, 3'h1, ext}};
        msk = '{20'he0400, '1, '1, 20'hfc381, '1, 20'he0400, 20'he0000, 20'he0000, '1, '1, '1};
        sys_rst <= 1'h1;
        repeat (5) @(posedge clk);
        sys_rst <= 1'h0;
        cmdLog.delete();
        apb(1'h1, `APB_EXT, {18'h0, ext});
        apb(1'h1, `APB_MODE, {18'h0, mode});
        apb(1'h1, `APB_CTRL, {30'h0, hot, 1'h1});
        while (ddr2_link_if_i.ready !== 1'h1)
        begin
            @(posedge clk);
        end
        `CHECK("init count", 11, cmdLog.size())
        for (int i = 0; i < 11; i++)
            `CHECK("init command", exp[i] & msk[i], cmdLog[i] & msk[i])
        apb(1'h0, `APB_STAT, 32'h0);
        `CHECK("status", 32'h0000001f, rdat)
        `CHECK("additive latency", ext[5:3], addLat)
        `CHECK("cas latency", mode[6:4], casLat)
        `CHECK("fast refresh", hot, hotRefresh)
        apb(1'h1, `APB_EXT, 32'h00000038);
        apb(1'h0, `APB_EXT, 32'h0);
        `CHECK("refused ext", {18'h0, ext}, rdat)
        apb(1'h1, `APB_MODE, 32'h00000022);
        apb(1'h0, `APB_MODE, 32'h0);
        `CHECK("refused mode", {18'h0, mode}, rdat)
        apb(1'h0, 8'h20, 32'h0);
        `CHECK("unmapped error", 1'h1, err)
        rdGap = -1;
        wrGap = -1;
        order(ddr2_cmd_pkg::CMD_ACT, 3'h1, 14'h0123);
        order(ddr2_cmd_pkg::CMD_ACT, 3'h2, 14'h0045);
        order(ddr2_cmd_pkg::CMD_RD, 3'h1, 14'h0010);
        order(ddr2_cmd_pkg::CMD_WR, 3'h2, 14'h0020);
        repeat (20) @(posedge clk);
        `CHECK("read latency", int'(ext[5:3]) + int'(mode[6:4]), rdGap)
        `CHECK("write latency", int'(ext[5:3]) + int'(mode[6:4]) - 1, wrGap)
        `CHECK("latency kept", ext[5:3], addLat)
        $display("config done hot %h ext %h mode %h", hot, ext, mode);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        run_cfg(1'h1, 14'h0010, 14'h0042);
        run_cfg(1'h0, 14'h0000, 14'h0032);
        run_cfg(1'h1, 14'h0030, 14'h0072);
        close_out();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        close_out();
    end
endmodule
